// ---- include/ssc_pkg.sv ----
// Purpose: Shared constants and types for the servo stop and forced-stop controller
// Assumes: 20 MHz pclk, APB register access with 32-bit data
// Notes: Speeds are unsigned magnitudes in the same units as the host speed command

package ssc_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_EST = 8'h00;
   localparam logic [7:0] OFS_SDT = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_ISTAT = 8'h14;
   localparam logic [7:0] OFS_IMASK = 8'h18;
   localparam logic [7:0] OFS_MAXTRQ = 8'h1c;
   localparam logic [7:0] OFS_MAXSPD = 8'h20;

   // ****************************************
   // Reset values and limits
   // ****************************************
   localparam logic [15:0] EST_RST = 16'h0320;
   localparam logic [15:0] EST_MAX = 16'h0320;
   localparam logic [15:0] SDT_RST = 16'h0000;
   localparam logic [15:0] SDT_MAX = 16'h2710;
   localparam logic [15:0] MAXTRQ_RST = 16'h012c;
   localparam logic [15:0] MAXSPD_RST = 16'h1770;
   localparam int unsigned CMD_ON_BIT = 0;
   localparam int unsigned CMD_OFF_BIT = 1;
   localparam int unsigned FRAC_W = 16;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned MS_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;

   // ****************************************
   // Stop method codes
   // ****************************************
   localparam logic [2:0] SM_TRQ_HOLD = 3'h1;
   localparam logic [2:0] SM_TRQ_COAST = 3'h2;
   localparam logic [2:0] SM_RAMP_HOLD = 3'h3;
   localparam logic [2:0] SM_RAMP_COAST = 3'h4;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic coast_sel;
      logic torque_mode;
      logic [2:0] stop_method_select;
   } ssc_ctrl_t;
   localparam ssc_ctrl_t CTRL_RST = 5'h00;

   typedef struct packed {
      logic on_refused;
      logic stop_done;
      logic forced_stop_input_event;
   } ssc_irq_t;
   localparam ssc_irq_t IRQ_RST = 3'h0;

   typedef enum logic [4:0] {
      ST_BB = 5'b00001,
      ST_RUN = 5'b00010,
      ST_TRQ = 5'b00100,
      ST_RAMP = 5'b01000,
      ST_HOLD = 5'b10000
   } ssc_state_t;

   function automatic logic [15:0] ssc_min16(input logic [15:0] a, input logic [15:0] b);
      ssc_min16 = (a < b) ? a : b;
   endfunction : ssc_min16

endpackage : ssc_pkg

// ---- rtl/ssc_div.sv ----
// Purpose: Serial restoring divider for the deceleration slope
// Assumes: Divisor is non-zero and held stable while busy
// Notes: One quotient bit per clock, NW cycles per division

`timescale 1ns/1ps

module ssc_div #(
   parameter int NW = 32,
   parameter int DW = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [NW-1:0] dividend,
   input wire logic [DW-1:0] divisor,
   output logic busy,
   output logic done,
   output logic [NW-1:0] quot
);
   localparam int CW = $clog2(NW + 1);

   logic [NW-1:0] num_q;
   logic [DW:0] rem_q;
   logic [DW-1:0] div_q;
   logic [CW-1:0] cnt_q;
   logic busy_q;
   logic done_q;
   logic [DW:0] trial;
   logic fits;

   always_comb begin
      trial = {rem_q[DW-1:0], num_q[NW-1]};
      fits = (trial >= {1'b0, div_q});
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         num_q <= '0;
         rem_q <= '0;
         div_q <= '0;
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start && !busy_q) begin
            num_q <= dividend;
            rem_q <= '0;
            div_q <= divisor;
            cnt_q <= CW'(NW);
            busy_q <= 1'b1;
         end else if (busy_q) begin
            rem_q <= fits ? (trial - {1'b0, div_q}) : trial;
            num_q <= {num_q[NW-2:0], fits};
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == CW'(1)) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign quot = num_q;

endmodule : ssc_div

// ---- rtl/ssc_stop_ctrl.sv ----
// Purpose: Stop control and forced-stop latch for one servo axis, APB registers
// Assumes: forced_stop_input is an asynchronous pin, high while the axis may run
// Notes: Speed command and feedback come from logic on pclk, unsigned magnitude
//
// How it works
// - Stop methods 1 and 2 brake to zero speed with torque capped at the stop torque.
// - The stop torque register takes 0 to 800 percent of rated torque and resets to 800.
// - The applied stop torque is further capped at the motor maximum torque.
// - The stop time register takes 0 to 10000 ms, resets to 0; a new value reaches the slope within two divisions.
// - A stop time of 0 sets the speed reference to zero at once, with no ramp.
// - The ramp slope is maximum speed divided by the stop time, applied per ms.
// - Servo-on while the forced stop input is off keeps the forced stop latched.
// - Methods 3 and 4 ramp down on the stop time; method 4 then coasts.
// - In torque control a stop goes straight to braking or coasting.
//
// The APB slave port and the register addresses were decided locally.

`timescale 1ns/1ps

module ssc_stop_ctrl import ssc_pkg::*; #(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic forced_stop_input,
   input wire logic [15:0] speed_cmd,
   input wire logic [15:0] speed_fb,
   output logic [15:0] speed_ref,
   output logic [15:0] torque_limit,
   output logic motor_power_on,
   output logic dyn_brake,
   output logic base_block_state,
   output logic forced_stop_latched,
   output logic irq
);
   localparam int MSW = $clog2(MS_CYCLES + 1);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ****************************************
   // APB slave
   // ****************************************
   logic [15:0] est_q;
   logic [15:0] sdt_q;
   logic [15:0] max_trq_q;
   logic [15:0] max_spd_q;
   ssc_ctrl_t ctrl_q;
   ssc_irq_t istat_q;
   ssc_irq_t imask_q;
   ssc_irq_t ev;
   ssc_state_t state_q;
   logic fs_latch_q;
   logic armed_q;
   logic forced_stop_input_s2_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic cmd_on_q;
   logic cmd_off_q;
   logic wr_en;
   logic rd_hit;
   logic [31:0] rd_val;

   // Zero wait states: ready rises in the cycle after setup
   assign wr_en = psel && penable && pwrite && pready_q;

   function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lim);
      clamp16 = (v > {16'h0000, lim}) ? lim : v[15:0];
   endfunction : clamp16

   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (paddr)
         OFS_EST: rd_val = {16'h0000, est_q};
         OFS_SDT: rd_val = {16'h0000, sdt_q};
         OFS_CTRL: rd_val = {27'h0000000, ctrl_q};
         OFS_CMD: rd_val = 32'h0000_0000;
         OFS_STAT: rd_val = {24'h000000, forced_stop_input_s2_q, armed_q, fs_latch_q, state_q};
         OFS_ISTAT: rd_val = {29'h00000000, istat_q};
         OFS_IMASK: rd_val = {29'h00000000, imask_q};
         OFS_MAXTRQ: rd_val = {16'h0000, max_trq_q};
         OFS_MAXSPD: rd_val = {16'h0000, max_spd_q};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !rd_hit;
         prdata_q <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         est_q <= EST_RST;
         sdt_q <= SDT_RST;
         ctrl_q <= CTRL_RST;
         imask_q <= IRQ_RST;
         max_trq_q <= MAXTRQ_RST;
         max_spd_q <= MAXSPD_RST;
         cmd_on_q <= 1'b0;
         cmd_off_q <= 1'b0;
      end else begin
         cmd_on_q <= wr_en && (paddr == OFS_CMD) && pwdata[CMD_ON_BIT];
         cmd_off_q <= wr_en && (paddr == OFS_CMD) && pwdata[CMD_OFF_BIT];
         if (wr_en) begin
            unique case (paddr)
               OFS_EST: est_q <= clamp16(pwdata, EST_MAX);
               OFS_SDT: sdt_q <= clamp16(pwdata, SDT_MAX);
               OFS_CTRL: ctrl_q <= pwdata[4:0];
               OFS_IMASK: imask_q <= pwdata[2:0];
               OFS_MAXTRQ: max_trq_q <= pwdata[15:0];
               OFS_MAXSPD: max_spd_q <= pwdata[15:0];
               default: ;
            endcase
         end
      end
   end

   a_est_range: assert property (est_q <= EST_MAX)
      else $error("stop torque setting above range");
   a_sdt_range: assert property (sdt_q <= SDT_MAX)
      else $error("stop time setting above range");

   // ****************************************
   // Forced stop input and latch
   // ****************************************
   logic forced_stop_input_s1_q;
   logic forced_stop_input_prev_q;
   logic forced_stop_input_fall;

   // Pin passes two flops; only the second one is looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Reset to the ON level, so a quiet pin neither latches nor fakes an edge
         forced_stop_input_s1_q <= 1'b1;
         forced_stop_input_s2_q <= 1'b1;
         forced_stop_input_prev_q <= 1'b1;
      end else begin
         forced_stop_input_s1_q <= forced_stop_input;
         forced_stop_input_s2_q <= forced_stop_input_s1_q;
         forced_stop_input_prev_q <= forced_stop_input_s2_q;
      end
   end
   assign forced_stop_input_fall = forced_stop_input_prev_q && !forced_stop_input_s2_q;

   logic fs_clear;
   assign fs_clear = (state_q == ST_BB) && armed_q && cmd_on_q && forced_stop_input_s2_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_latch_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         // Input off sets the latch; this wins over any clear in the same cycle
         if (!forced_stop_input_s2_q) begin
            fs_latch_q <= 1'b1;
            armed_q <= 1'b0;
         end else if (fs_clear) begin
            fs_latch_q <= 1'b0;
            armed_q <= 1'b0;
         end else if (fs_latch_q && cmd_off_q) begin
            armed_q <= 1'b1;
         end
      end
   end

   a_fs_hold: assert property (fs_latch_q && cmd_on_q && !armed_q |=> fs_latch_q)
      else $error("forced stop cleared without servo-off first");

   // ****************************************
   // Deceleration slope
   // ****************************************
   logic div_done;
   logic [31:0] div_quot;
   logic [31:0] step_q;

   // Free-running, so a new stop time or speed limit reaches the slope within two divisions
   ssc_div #(.NW(32), .DW(16)) u_div (
      .clk(pclk),
      .rst_n(presetn),
      .start(sdt_q != 16'h0000),
      .dividend({max_spd_q, 16'h0000}),
      .divisor(sdt_q),
      .busy(),
      .done(div_done),
      .quot(div_quot)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_q <= 32'h0000_0000;
      end else if (div_done) begin
         step_q <= div_quot;
      end
   end

   logic [MSW-1:0] ms_cnt_q;
   logic ms_tick;
   assign ms_tick = (ms_cnt_q == MSW'(MS_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_q <= '0;
      end else begin
         ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
      end
   end

   // ****************************************
   // Stop sequencer
   // ****************************************
   ssc_state_t state_d;
   logic stop_req;
   logic [2:0] method;
   logic on_ok;
   logic [31:0] spd_fx_q;
   logic [15:0] lim;

   assign method = ctrl_q.stop_method_select;
   assign stop_req = cmd_off_q || !forced_stop_input_s2_q;
   assign on_ok = cmd_on_q && forced_stop_input_s2_q && (!fs_latch_q || fs_clear);
   assign lim = ssc_min16(est_q, max_trq_q);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_BB: begin
            if (on_ok) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stop_req) begin
               if (ctrl_q.torque_mode) begin
                  state_d = ST_BB;
               end else if (method == SM_TRQ_HOLD || method == SM_TRQ_COAST) begin
                  state_d = ST_TRQ;
               end else if (method == SM_RAMP_HOLD || method == SM_RAMP_COAST) begin
                  if (sdt_q != 16'h0000) begin
                     state_d = ST_RAMP;
                  end else begin
                     state_d = (method == SM_RAMP_COAST) ? ST_BB : ST_HOLD;
                  end
               end else begin
                  state_d = ST_BB;
               end
            end
         end
         ST_TRQ: begin
            if (speed_fb == 16'h0000) begin
               state_d = (method == SM_TRQ_COAST) ? ST_BB : ST_HOLD;
            end
         end
         ST_RAMP: begin
            if (spd_fx_q[31:FRAC_W] == 16'h0000) begin
               state_d = (method == SM_RAMP_COAST) ? ST_BB : ST_HOLD;
            end
         end
         ST_HOLD: begin
            // Zero-speed lock until servo-off, or at once after a plain servo-off stop
            if (cmd_off_q || armed_q || !fs_latch_q) begin
               state_d = ST_BB;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_BB;
      end else begin
         state_q <= state_d;
      end
   end

   // Ramp runs on a fixed-point copy of the reference so small slopes still move it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spd_fx_q <= 32'h0000_0000;
      end else if (state_q == ST_RUN && state_d == ST_RUN) begin
         spd_fx_q <= {speed_cmd, 16'h0000};
      end else if (state_q == ST_RAMP) begin
         if (sdt_q == 16'h0000) begin
            spd_fx_q <= 32'h0000_0000;
         end else if (ms_tick) begin
            spd_fx_q <= (spd_fx_q > step_q) ? spd_fx_q - step_q : 32'h0000_0000;
         end
      end else if (state_q != ST_RUN) begin
         spd_fx_q <= 32'h0000_0000;
      end
   end

   // ****************************************
   // Drive outputs
   // ****************************************
   logic [15:0] speed_ref_q;
   logic [15:0] torque_limit_q;
   logic power_q;
   logic brake_q;
   logic bb_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_ref_q <= 16'h0000;
         torque_limit_q <= 16'h0000;
         power_q <= 1'b0;
         brake_q <= 1'b1;
         bb_q <= 1'b1;
      end else begin
         power_q <= (state_d != ST_BB);
         bb_q <= (state_d == ST_BB);
         brake_q <= (state_d == ST_BB) && !ctrl_q.coast_sel;
         unique case (state_d)
            ST_RUN: begin
               speed_ref_q <= speed_cmd;
               torque_limit_q <= max_trq_q;
            end
            ST_TRQ: begin
               speed_ref_q <= 16'h0000;
               torque_limit_q <= lim;
            end
            ST_RAMP: begin
               speed_ref_q <= spd_fx_q[31:FRAC_W];
               torque_limit_q <= max_trq_q;
            end
            ST_HOLD: begin
               speed_ref_q <= 16'h0000;
               torque_limit_q <= max_trq_q;
            end
            ST_BB: begin
               speed_ref_q <= 16'h0000;
               torque_limit_q <= 16'h0000;
            end
         endcase
      end
   end

   a_trq_cap: assert property (state_q == ST_TRQ && $past(state_q == ST_TRQ)
         |-> torque_limit_q <= max_trq_q && torque_limit_q <= est_q)
      else $error("stop torque above a limit");
   a_trq_entry: assert property (state_q == ST_RUN && stop_req && !ctrl_q.torque_mode
         && method == SM_TRQ_COAST |=> state_q == ST_TRQ && speed_ref_q == 16'h0000)
      else $error("torque stop not entered");
   a_zero_time: assert property (state_q == ST_RUN && stop_req && !ctrl_q.torque_mode
         && method == SM_RAMP_HOLD && sdt_q == 16'h0000
         |=> state_q == ST_HOLD && speed_ref_q == 16'h0000)
      else $error("zero stop time did not stop at once");
   a_ramp_down: assert property (state_q == ST_RAMP && $past(state_q == ST_RAMP)
         |-> spd_fx_q <= $past(spd_fx_q))
      else $error("ramp reference rose");
   a_coast_end: assert property (state_q == ST_RAMP && method == SM_RAMP_COAST
         && spd_fx_q[31:FRAC_W] == 16'h0000 |=> !motor_power_on ##1 !motor_power_on)
      else $error("method 4 did not coast after ramp");
   a_trq_mode: assert property (state_q == ST_RUN && stop_req && ctrl_q.torque_mode
         |=> state_q == ST_BB && !motor_power_on)
      else $error("torque control stop was decelerated");
   a_fs_nopower: assert property (state_q == ST_BB && fs_latch_q && !fs_clear
         |=> !motor_power_on)
      else $error("power applied while forced stop latched");

   // ****************************************
   // Interrupts
   // ****************************************
   logic irq_q;

   always_comb begin
      ev.forced_stop_input_event = forced_stop_input_fall;
      ev.stop_done = (state_q inside {ST_TRQ, ST_RAMP, ST_RUN})
         && (state_d == ST_BB || state_d == ST_HOLD);
      ev.on_refused = cmd_on_q && !on_ok;
   end

   // Write one to clear; an event in the same cycle keeps its bit set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_q <= IRQ_RST;
         irq_q <= 1'b0;
      end else begin
         if (wr_en && paddr == OFS_ISTAT) begin
            istat_q <= (istat_q & ~ssc_irq_t'(pwdata[2:0])) | ev;
         end else begin
            istat_q <= istat_q | ev;
         end
         irq_q <= |(istat_q & imask_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign speed_ref = speed_ref_q;
   assign torque_limit = torque_limit_q;
   assign motor_power_on = power_q;
   assign dyn_brake = brake_q;
   assign base_block_state = bb_q;
   assign forced_stop_latched = fs_latch_q;
   assign irq = irq_q;

endmodule : ssc_stop_ctrl

// ---- testbench/ssc_host_model.sv ----
// Purpose: Host controller model that issues APB accesses and servo commands
// Assumes: The bench calls its tasks from one process only
// Notes: Every APB signal changes by NBA just after a rising edge

`timescale 1ns/1ps

module ssc_host_model import ssc_pkg::*; (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // Idle edge first, so no signal is assigned twice in one time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cmd(input int unsigned b);
      logic [31:0] r;
      logic e;
      apb(1'b1, OFS_CMD, 32'h1 << b, r, e);
   endtask : cmd

   // Servo-off first arms the forced stop clear, then servo-on
   task automatic clear_stop();
      cmd(CMD_OFF_BIT);
      cmd(CMD_ON_BIT);
   endtask : clear_stop
endmodule : ssc_host_model

// ---- testbench/ssc_stop_ctrl_tb_top.sv ----
// Purpose: Self-checking bench for the servo stop controller
// Assumes: MS_CYCLES shortened to 20 so ramps stay short
// Notes: Register rows first, then stop cases, then the forced stop latch

`timescale 1ns/1ps

module ssc_stop_ctrl_tb_top import ssc_pkg::*;;
   // ****************************************
   // Signals and instances
   // ****************************************
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} ssc_row_t;
   typedef struct {logic [4:0] c; logic [15:0] t; logic [15:0] q; logic [4:0] s; logic b;} ssc_case_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fsi, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] spd_fb, speed_ref, torque_limit, a0;
   logic mpo, dbk, bbs, fsl, e;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   ssc_row_t rows[9] = '{
      '{0, 8'h00, 32'h0, 32'h320, 0}, '{0, 8'h04, 32'h0, 32'h0, 0},
      '{0, 8'h1c, 32'h0, 32'h12c, 0}, '{0, 8'h14, 32'h0, 32'h0, 0},
      '{1, 8'h00, 32'h3e8, 32'h320, 0}, '{1, 8'h04, 32'h2711, 32'h2710, 0},
      '{1, 8'h18, 32'h1, 32'h1, 0}, '{1, 8'h24, 32'h5, 32'h0, 1},
      '{1, 8'h10, 32'hff, 32'h81, 0}};
   ssc_case_t cases[7] = '{
      '{5'h01, 16'ha, 16'h64, 5'h01, 1}, '{5'h02, 16'ha, 16'h320, 5'h01, 1},
      '{5'h03, 16'ha, 16'h320, 5'h01, 1}, '{5'h04, 16'ha, 16'h320, 5'h01, 1},
      '{5'h03, 16'h0, 16'h320, 5'h01, 1}, '{5'h09, 16'ha, 16'h320, 5'h01, 1},
      '{5'h19, 16'ha, 16'h320, 5'h01, 0}};

   ssc_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   ssc_stop_ctrl #(.MS_CYCLES(20)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .forced_stop_input(fsi), .speed_cmd(16'h1770),
      .speed_fb(spd_fb), .speed_ref(speed_ref), .torque_limit(torque_limit),
      .motor_power_on(mpo), .dyn_brake(dbk), .base_block_state(bbs),
      .forced_stop_latched(fsl), .irq(irq));

   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      tests_run++;
      if (s !== x) begin
         err_count++;
         $display("[FAIL] %s exp %h seen %h", n, x, s);
      end
   endtask : chk

   task automatic results();
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      presetn = 1'b0;
      fsi = 1'b1;
      spd_fb = 16'h0;
      wt(20);
      presetn <= 1'b1;
      chk("bb_after_reset", {mpo, bbs, dbk}, 3'b011);
      foreach (rows[i]) begin
         if (rows[i].w) host.apb(1'b1, rows[i].a, rows[i].d, r, e);
         host.apb(1'b0, rows[i].a, 32'h0, r, e);
         chk("reg_read", {e, r}, {rows[i].e, rows[i].x});
      end
      // Stop methods; divider gets 40 cycles to settle after a time change
      foreach (cases[i]) begin
         host.apb(1'b1, OFS_CTRL, {27'h0, cases[i].c}, r, e);
         host.apb(1'b1, OFS_SDT, {16'h0, cases[i].t}, r, e);
         host.apb(1'b1, OFS_EST, {16'h0, cases[i].q}, r, e);
         host.cmd(CMD_OFF_BIT);
         wt(40);
         host.cmd(CMD_ON_BIT);
         spd_fb <= 16'h1770;
         wt(4);
         chk("run_power", mpo, 1'b1);
         host.cmd(CMD_OFF_BIT);
         wt(4);
         if (cases[i].c[3] == 1'b0 && cases[i].c[2:0] < 3'h3) begin
            chk("stop_torque", torque_limit, (cases[i].q < 16'h12c) ? cases[i].q : 16'h12c);
         end
         if (cases[i].c[3] == 1'b0 && cases[i].c[2:0] > 3'h2 && cases[i].t != 16'h0) begin
            a0 = speed_ref;
            wt(20);
            chk("ramp_step", a0 - speed_ref, 16'h0258);
         end else begin
            chk("zero_speed", speed_ref, 16'h0);
         end
         spd_fb <= 16'h0;
         wt(250);
         host.apb(1'b0, OFS_STAT, 32'h0, r, e);
         chk("end_state", {r[4:0], dbk}, {cases[i].s, cases[i].b});
      end
      // Forced stop latch, refusal, interrupt and clearing sequence
      host.cmd(CMD_OFF_BIT);
      host.cmd(CMD_ON_BIT);
      wt(4);
      fsi <= 1'b0;
      wt(6);
      chk("latch_power", {fsl, mpo, irq}, 3'b101);
      host.cmd(CMD_ON_BIT);
      host.apb(1'b0, OFS_ISTAT, 32'h0, r, e);
      chk("refused", r[2:0], 3'b111);
      fsi <= 1'b1;
      wt(6);
      host.cmd(CMD_ON_BIT);
      wt(4);
      chk("kept_latched", {fsl, mpo}, 2'b10);
      host.apb(1'b1, OFS_IMASK, 32'h0, r, e);
      wt(3);
      chk("irq_masked", irq, 1'b0);
      host.apb(1'b1, OFS_IMASK, 32'h1, r, e);
      wt(3);
      chk("irq_unmasked", irq, 1'b1);
      host.apb(1'b1, OFS_ISTAT, 32'h7, r, e);
      wt(3);
      chk("irq_cleared", irq, 1'b0);
      host.clear_stop();
      wt(4);
      chk("cleared", {fsl, mpo}, 2'b01);
      results();
   end
endmodule : ssc_stop_ctrl_tb_top
